// ==== hgcs_config_status.v ====
// Shared configuration and status register bank of the deserializer hub
//
// What this block does
// R1 - The local I2C controller is enabled only while config bit 5 is 1.
// R2 - Lock policy 0 with no assigned port locked forces the TX port to hi-Z.
// R3 - Lock policy 1 keeps TX running, entering LP-11 when none is locked, idle select is 1 and output enable is 1.
// R4 - Idle select 1 with output enable bit 3 at 0 holds the TX outputs hi-Z.
// R5 - Idle select bit 2 at 0 with lock policy 1 and lock low forces the TX outputs to HS-0.
// R6 - Receive parity checking runs while config bit 1 is 1, its default.
// R7 - Config bit 0 at 1 reports the reference clock present regardless.
// R8 - A read-only byte holds silicon step code high and mask code low.
// R9 - Status bit 7 is set after init only when the fuse checksum was valid.
// R10 - Status bit 6 is set once power-up initialisation has completed.
// R11 - Status bit 4 shows the reference clock frequency lies within limits.
// R12 - Each port's parity flag sets once its error count reaches the limit.
// R13 - Limit bits 15:8 come from the high byte register, reset to one.
// R14 - Limit bits 7:0 come from the low byte register, reset to zero.
// R15 - Config bits 7 and 6 read as zero and ignore writes.
// R16 - Each count is compared against the full current limit as it changes.
`timescale 1ns/100ps
`include "hgcs_map.vh"

module hgcs_config_status #(
	parameter NUM_PORTS = 4,
	parameter [3:0] SILICON_STEP = 4'h0, // Arbitrary value
	parameter [3:0] MASK_STEP = 4'h0 // Arbitrary value
) (
	input wire i_clk,
	input wire i_resetn,
	input wire [7:0] i_reg_addr,
	input wire i_reg_wr,
	input wire [7:0] i_reg_wdata,
	output reg [7:0] o_reg_rdata,
	input wire i_init_done,
	input wire i_cksum_ok,
	input wire i_ref_clock_detect,
	input wire i_ref_clock_in_range,
	input wire [NUM_PORTS-1:0] i_port_assigned,
	input wire [NUM_PORTS-1:0] i_port_lock,
	input wire [NUM_PORTS*16-1:0] i_parity_err_count,
	output reg o_i2c_ctrl_en,
	output reg o_parity_check_en,
	output reg o_ref_clock_present,
	output reg [1:0] o_tx_state,
	output reg [NUM_PORTS-1:0] o_parity_error_flag
);

	// ************************************************************
	// Local constants
	// ************************************************************
	localparam CNT_W = 16;
	localparam [5:0] CFG_RESET = `HGCS_CFG_RESET;
	localparam [7:0] STS_RESET = `HGCS_STS_RESET;
	localparam [7:0] THR_HI_RESET = `HGCS_THR_HI_RESET;
	localparam [7:0] THR_LO_RESET = `HGCS_THR_LO_RESET;
	localparam [7:0] RDATA_RESET = `HGCS_RDATA_RESET;
	localparam [1:0] TX_NORMAL = `HGCS_TX_NORMAL;
	localparam [1:0] TX_HIZ = `HGCS_TX_HIZ;
	localparam [1:0] TX_HS0 = `HGCS_TX_HS0;
	localparam [1:0] TX_LP11 = `HGCS_TX_LP11;

	// ************************************************************
	// Internal state and next values
	// ************************************************************
	reg i2c_en_reg;
	reg i2c_en_next;
	reg lock_policy_reg;
	reg lock_policy_next;
	reg out_en_reg;
	reg out_en_next;
	reg idle_sel_reg;
	reg idle_sel_next;
	reg parity_en_reg;
	reg parity_en_next;
	reg ref_ovr_reg;
	reg ref_ovr_next;
	reg [7:0] thr_hi_reg;
	reg [7:0] thr_hi_next;
	reg [7:0] thr_lo_reg;
	reg [7:0] thr_lo_next;
	reg cksum_reg;
	reg cksum_next;
	reg init_reg;
	reg init_next;
	reg reference_clock_input_reg;
	reg reference_clock_input_next;
	reg [7:0] status_word;
	reg [7:0] rdata_next;
	reg [1:0] tx_next;
	reg i2c_out_next;
	reg parity_out_next;
	reg ref_out_next;
	wire [5:0] cfg_word;
	wire [CNT_W-1:0] limit;
	wire hit_cfg;
	wire hit_rev;
	wire hit_sts;
	wire hit_thr_hi;
	wire hit_thr_lo;
	wire wr_cfg;
	wire wr_thr_hi;
	wire wr_thr_lo;
	wire any_locked;
	wire force_off;
	wire [NUM_PORTS-1:0] reached;

	// ************************************************************
	// Address decode
	// ************************************************************
	assign hit_cfg = (i_reg_addr == `HGCS_ADDR_GEN_CFG);
	assign hit_rev = (i_reg_addr == `HGCS_ADDR_REV);
	assign hit_sts = (i_reg_addr == `HGCS_ADDR_STATUS);
	assign hit_thr_hi = (i_reg_addr == `HGCS_ADDR_THR_HI);
	assign hit_thr_lo = (i_reg_addr == `HGCS_ADDR_THR_LO);
	// Revision and status take no write
	assign wr_cfg = i_reg_wr & hit_cfg;
	assign wr_thr_hi = i_reg_wr & hit_thr_hi;
	assign wr_thr_lo = i_reg_wr & hit_thr_lo;

	// ************************************************************
	// Configuration fields
	// ************************************************************
	always @* begin
		i2c_en_next = i2c_en_reg;
		lock_policy_next = lock_policy_reg;
		out_en_next = out_en_reg;
		idle_sel_next = idle_sel_reg;
		parity_en_next = parity_en_reg;
		ref_ovr_next = ref_ovr_reg;
		if (wr_cfg) begin
			// Bits 7 and 6 are dropped
			i2c_en_next = i_reg_wdata[`HGCS_CFG_I2C_EN]; // R15
			lock_policy_next = i_reg_wdata[`HGCS_CFG_LOCK_POLICY];
			out_en_next = i_reg_wdata[`HGCS_CFG_OUT_EN];
			idle_sel_next = i_reg_wdata[`HGCS_CFG_IDLE_SEL];
			parity_en_next = i_reg_wdata[`HGCS_CFG_PARITY_EN];
			ref_ovr_next = i_reg_wdata[`HGCS_CFG_REFERENCE_CLOCK_INPUT_OVR];
		end
	end

	always @(posedge i_clk) begin
		if (!i_resetn)
			i2c_en_reg <= CFG_RESET[`HGCS_CFG_I2C_EN];
		else
			i2c_en_reg <= i2c_en_next;
	end

	always @(posedge i_clk) begin
		if (!i_resetn)
			lock_policy_reg <= CFG_RESET[`HGCS_CFG_LOCK_POLICY];
		else
			lock_policy_reg <= lock_policy_next;
	end

	always @(posedge i_clk) begin
		if (!i_resetn)
			out_en_reg <= CFG_RESET[`HGCS_CFG_OUT_EN];
		else
			out_en_reg <= out_en_next;
	end

	always @(posedge i_clk) begin
		if (!i_resetn)
			idle_sel_reg <= CFG_RESET[`HGCS_CFG_IDLE_SEL];
		else
			idle_sel_reg <= idle_sel_next;
	end

	always @(posedge i_clk) begin
		if (!i_resetn)
			parity_en_reg <= CFG_RESET[`HGCS_CFG_PARITY_EN];
		else
			parity_en_reg <= parity_en_next;
	end

	always @(posedge i_clk) begin
		if (!i_resetn)
			ref_ovr_reg <= CFG_RESET[`HGCS_CFG_REFERENCE_CLOCK_INPUT_OVR];
		else
			ref_ovr_reg <= ref_ovr_next;
	end

	assign cfg_word = {i2c_en_reg, lock_policy_reg, out_en_reg,
		idle_sel_reg, parity_en_reg, ref_ovr_reg};

	// ************************************************************
	// Parity threshold bytes
	// ************************************************************
	always @* begin
		thr_hi_next = thr_hi_reg;
		thr_lo_next = thr_lo_reg;
		if (wr_thr_hi)
			thr_hi_next = i_reg_wdata;
		if (wr_thr_lo)
			thr_lo_next = i_reg_wdata;
	end

	always @(posedge i_clk) begin
		if (!i_resetn)
			thr_hi_reg <= THR_HI_RESET; // R13
		else
			thr_hi_reg <= thr_hi_next;
	end

	always @(posedge i_clk) begin
		if (!i_resetn)
			thr_lo_reg <= THR_LO_RESET; // R14
		else
			thr_lo_reg <= thr_lo_next;
	end

	assign limit = {thr_hi_reg, thr_lo_reg}; // R13 R14

	// ************************************************************
	// Status capture
	// ************************************************************
	always @* begin
		cksum_next = i_init_done & i_cksum_ok; // R9
		init_next = i_init_done; // R10
		reference_clock_input_next = i_ref_clock_in_range; // R11
	end

	always @(posedge i_clk) begin
		if (!i_resetn)
			cksum_reg <= STS_RESET[`HGCS_STS_CKSUM];
		else
			cksum_reg <= cksum_next;
	end

	always @(posedge i_clk) begin
		if (!i_resetn)
			init_reg <= STS_RESET[`HGCS_STS_INIT];
		else
			init_reg <= init_next;
	end

	always @(posedge i_clk) begin
		if (!i_resetn)
			reference_clock_input_reg <= STS_RESET[`HGCS_STS_REFERENCE_CLOCK_INPUT];
		else
			reference_clock_input_reg <= reference_clock_input_next;
	end

	always @* begin
		status_word = 8'h00;
		status_word[`HGCS_STS_CKSUM] = cksum_reg;
		status_word[`HGCS_STS_INIT] = init_reg;
		status_word[`HGCS_STS_REFERENCE_CLOCK_INPUT] = reference_clock_input_reg;
	end

	// ************************************************************
	// Register read
	// ************************************************************
	always @* begin
		if (hit_cfg)
			rdata_next = {2'h0, cfg_word}; // R15
		else if (hit_rev)
			rdata_next = {SILICON_STEP, MASK_STEP}; // R8
		else if (hit_sts)
			rdata_next = status_word;
		else if (hit_thr_hi)
			rdata_next = thr_hi_reg;
		else if (hit_thr_lo)
			rdata_next = thr_lo_reg;
		else
			rdata_next = 8'h00;
	end

	always @(posedge i_clk) begin
		if (!i_resetn)
			o_reg_rdata <= RDATA_RESET;
		else
			o_reg_rdata <= rdata_next;
	end

	// ************************************************************
	// Transmit output policy
	// ************************************************************
	assign any_locked = |(i_port_assigned & i_port_lock);
	assign force_off = idle_sel_reg & ~out_en_reg; // R4

	// Output-off setting wins over lock
	always @* begin
		if (force_off)
			tx_next = TX_HIZ; // R4
		else if (any_locked)
			tx_next = TX_NORMAL;
		else if (!lock_policy_reg)
			tx_next = TX_HIZ; // R2
		else if (!idle_sel_reg)
			tx_next = TX_HS0; // R5
		else
			tx_next = TX_LP11; // R3
	end

	always @(posedge i_clk) begin
		if (!i_resetn)
			o_tx_state <= TX_HIZ;
		else
			o_tx_state <= tx_next;
	end

	// ************************************************************
	// Enable outputs
	// ************************************************************
	always @* begin
		i2c_out_next = i2c_en_reg; // R1
		parity_out_next = parity_en_reg; // R6
		ref_out_next = ref_ovr_reg | i_ref_clock_detect; // R7
	end

	always @(posedge i_clk) begin
		if (!i_resetn)
			o_i2c_ctrl_en <= CFG_RESET[`HGCS_CFG_I2C_EN];
		else
			o_i2c_ctrl_en <= i2c_out_next;
	end

	always @(posedge i_clk) begin
		if (!i_resetn)
			o_parity_check_en <= CFG_RESET[`HGCS_CFG_PARITY_EN];
		else
			o_parity_check_en <= parity_out_next;
	end

	always @(posedge i_clk) begin
		if (!i_resetn)
			o_ref_clock_present <= CFG_RESET[`HGCS_CFG_REFERENCE_CLOCK_INPUT_OVR];
		else
			o_ref_clock_present <= ref_out_next;
	end

	// ************************************************************
	// Per-port parity error flags
	// ************************************************************
	// Level compare against the live limit, not sticky
	genvar p;
	generate
		for (p = 0; p < NUM_PORTS; p = p + 1) begin : g_port
			wire [CNT_W-1:0] count;
			assign count = i_parity_err_count[p*CNT_W +: CNT_W];
			assign reached[p] = (count >= limit); // R12 R16
		end
	endgenerate

	always @(posedge i_clk) begin
		if (!i_resetn)
			o_parity_error_flag <= {NUM_PORTS{1'b0}};
		else
			o_parity_error_flag <= reached; // R12
	end

endmodule

// ==== hgcs_host.sv ====
// Register host model for the bank's write and read port
`timescale 1ns/100ps
module hgcs_host (
	input wire i_clk,
	input wire [7:0] i_rdata,
	output reg [7:0] o_addr = 8'h00,
	output reg o_wr = 1'h0,
	output reg [7:0] o_wdata = 8'h00
);
	task put(input [7:0] a, input [7:0] v);
		o_addr = a;
		o_wdata = v;
		o_wr = 1'h1;
		@(posedge i_clk) #1;
		o_wr = 1'h0;
		@(posedge i_clk) #1;
	endtask
	task get(input [7:0] a, output [7:0] v);
		o_wr = 1'h0;
		o_addr = a;
		repeat (2) @(posedge i_clk);
		#1 v = i_rdata;
	endtask
endmodule

// ==== hgcs_map.vh ====
// Register offsets, field positions and reset values of the hub config bank
`ifndef HGCS_MAP_VH
`define HGCS_MAP_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define HGCS_ADDR_GEN_CFG 8'h02
`define HGCS_ADDR_REV 8'h03
`define HGCS_ADDR_STATUS 8'h04
`define HGCS_ADDR_THR_HI 8'h05
`define HGCS_ADDR_THR_LO 8'h06

// ****************************************************************
// General configuration fields
// ****************************************************************
`define HGCS_CFG_I2C_EN 5
`define HGCS_CFG_LOCK_POLICY 4
`define HGCS_CFG_OUT_EN 3
`define HGCS_CFG_IDLE_SEL 2
`define HGCS_CFG_PARITY_EN 1
`define HGCS_CFG_REFERENCE_CLOCK_INPUT_OVR 0
`define HGCS_CFG_RESET 6'h1e

// ****************************************************************
// Status fields and threshold resets
// ****************************************************************
`define HGCS_STS_CKSUM 7
`define HGCS_STS_INIT 6
`define HGCS_STS_REFERENCE_CLOCK_INPUT 4
`define HGCS_STS_RESET 8'h00
`define HGCS_RDATA_RESET 8'h00
`define HGCS_THR_HI_RESET 8'h01
`define HGCS_THR_LO_RESET 8'h00

// ****************************************************************
// Transmit output states
// ****************************************************************
`define HGCS_TX_NORMAL 2'h0
`define HGCS_TX_HIZ 2'h1
`define HGCS_TX_HS0 2'h2
`define HGCS_TX_LP11 2'h3

`endif

// ==== hgcs_monitor.sv ====
// Assertion checker for the hub configuration bank
`timescale 1ns/100ps
module hgcs_monitor #(parameter NUM_PORTS = 4) (
	input wire i_clk, i_resetn, i_reg_wr, i_ref_clock_detect,
	input wire [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata,
	input wire [NUM_PORTS-1:0] i_port_assigned, i_port_lock,
	input wire [NUM_PORTS*16-1:0] i_parity_err_count,
	input wire o_i2c_ctrl_en, o_parity_check_en, o_ref_clock_present,
	input wire [1:0] o_tx_state,
	input wire [NUM_PORTS-1:0] o_parity_error_flag
);
	reg [5:0] cfg_reg;
	wire lk = |(i_port_lock & i_port_assigned);
	wire [1:0] tx_e = cfg_reg[3:2] == 2'h1 ? 2'h1 : lk ? 2'h0 :
		!cfg_reg[4] ? 2'h1 : {1'b1, cfg_reg[2]};
	always @(posedge i_clk) begin
		if (!i_resetn)
			cfg_reg <= 6'h1e;
		else if (i_reg_wr && i_reg_addr == 8'h02)
			cfg_reg <= i_reg_wdata[5:0];
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_resetn);
	property p_en; i_resetn |=> o_i2c_ctrl_en == $past(cfg_reg[5]);
	endproperty
	a_en: assert property (p_en) else $error("i2c enable");
	property p_par; i_resetn |=> o_parity_check_en == $past(cfg_reg[1]);
	endproperty
	a_par: assert property (p_par) else $error("parity enable");
	property p_ref; i_resetn |=> o_ref_clock_present ==
		$past(cfg_reg[0] | i_ref_clock_detect); endproperty
	a_ref: assert property (p_ref) else $error("ref clock");
	property p_tx; i_resetn |=> o_tx_state == $past(tx_e); endproperty
	a_tx: assert property (p_tx) else $error("tx state");
	property p_oe; cfg_reg[3:2] == 2'h1 |=> o_tx_state == 2'h1; endproperty
	a_oe: assert property (p_oe) else $error("tx off");
	property p_rd; i_reg_addr == 8'h02 && !i_reg_wr |=>
		o_reg_rdata == {2'h0, $past(cfg_reg)}; endproperty
	a_rd: assert property (p_rd) else $error("config read");
	property p_rev; i_reg_addr == 8'h03 |=> o_reg_rdata == 8'h00; endproperty
	a_rev: assert property (p_rev) else $error("revision");
	property p_fl; &i_parity_err_count[NUM_PORTS*16-1 -: 16] |=>
		o_parity_error_flag[NUM_PORTS-1]; endproperty
	a_fl: assert property (p_fl) else $error("parity flag");
endmodule
bind hgcs_config_status hgcs_monitor #(.NUM_PORTS(NUM_PORTS)) u_mon(.*);

// ==== testbench.sv ====
// Self-checking bench for the hub configuration bank
`timescale 1ns/100ps
module testbench;
	localparam [95:0] TAB = {16'h0001, 16'h1820, 16'h1802, 16'h14f1,
		16'h2c01, 16'hff03};
	reg i_clk = 1'h0, i_resetn = 1'h0, i_init_done = 1'h0;
	reg i_cksum_ok = 1'h0, i_ref_clock_detect = 1'h0;
	reg i_ref_clock_in_range = 1'h0;
	reg [3:0] i_port_assigned = 4'hf, i_port_lock = 4'h0;
	reg [63:0] i_parity_err_count = 64'h0;
	wire [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata;
	wire i_reg_wr, o_i2c_ctrl_en, o_parity_check_en, o_ref_clock_present;
	wire [1:0] o_tx_state;
	wire [3:0] o_parity_error_flag;
	integer bad_count = 0, n_tests = 0, k;
	reg [7:0] d, c;
	hgcs_config_status u_dut(.i_clk(i_clk), .i_resetn(i_resetn),
		.i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
		.i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
		.i_init_done(i_init_done), .i_cksum_ok(i_cksum_ok),
		.i_ref_clock_detect(i_ref_clock_detect),
		.i_ref_clock_in_range(i_ref_clock_in_range),
		.i_port_assigned(i_port_assigned), .i_port_lock(i_port_lock),
		.i_parity_err_count(i_parity_err_count),
		.o_i2c_ctrl_en(o_i2c_ctrl_en),
		.o_parity_check_en(o_parity_check_en),
		.o_ref_clock_present(o_ref_clock_present),
		.o_tx_state(o_tx_state),
		.o_parity_error_flag(o_parity_error_flag));
	hgcs_host u_host(.i_clk(i_clk), .i_rdata(o_reg_rdata),
		.o_addr(i_reg_addr), .o_wr(i_reg_wr), .o_wdata(i_reg_wdata));
	initial forever #10 i_clk = ~i_clk;
	task chk(input [15:0] g, input [15:0] e);
		n_tests = n_tests + 1;
		if (g !== e) bad_count = bad_count + 1;
		if (g !== e) $display("CHECK FAILED %0t got %h not %h", $time, g, e);
	endtask
	task t_cfg;
		u_host.get(8'h02, d);
		chk({d, o_tx_state}, 10'h07b);
		for (k = 0; k < 6; k = k + 1) begin
			c = TAB[k*16+8 +: 8];
			i_port_lock = TAB[k*16+4 +: 4];
			u_host.put(8'h02, c);
			u_host.get(8'h02, d);
			chk({d, o_i2c_ctrl_en, o_parity_check_en,
				o_ref_clock_present, o_tx_state},
				{c & 8'h3f, c[5], c[1], c[0],
				TAB[k*16 +: 2]});
		end
		i_ref_clock_detect = 1'h1;
		u_host.get(8'h02, d);
		chk({d, o_ref_clock_present}, 9'h001);
		$display("config test done");
	endtask
	task t_sts;
		for (k = 0; k < 8; k = k + 1) begin
			{i_init_done, i_cksum_ok, i_ref_clock_in_range} = k[2:0];
			u_host.get(8'h04, d);
			chk(d, {k[2] & k[1], k[2], 1'b0, k[0], 4'h0});
		end
		u_host.put(8'h03, 8'hff);
		u_host.put(8'h40, 8'hff);
		u_host.get(8'h03, d);
		chk(d, 8'h00);
		$display("status test done");
	endtask
	task t_par;
		u_host.get(8'h06, d);
		chk(d, 8'h00);
		i_parity_err_count = {16'hffff, 16'h0101, 16'h0100, 16'h00ff};
		u_host.get(8'h05, d);
		chk({d, o_parity_error_flag}, 12'h01e);
		i_parity_err_count = {16'h0003, 16'h0000, 16'h0001, 16'h0002};
		u_host.put(8'h05, 8'h00);
		u_host.put(8'h06, 8'h02);
		u_host.get(8'h06, d);
		chk({d, o_parity_error_flag}, 12'h029);
		$display("parity test done");
	endtask
	task t_rst;
		u_host.put(8'h05, 8'h7e);
		i_resetn = 1'h0;
		@(posedge i_clk) #1;
		i_resetn = 1'h1;
		u_host.get(8'h05, d);
		chk({d, o_tx_state, o_parity_check_en, o_parity_error_flag},
			15'h00f0);
		$display("reset test done");
	endtask
	task end_of_test;
		$display("tests %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge i_clk);
		#1 i_resetn = 1'h1;
		t_cfg;
		t_sts;
		t_par;
		t_rst;
		end_of_test;
	end
endmodule
